// [logic/bpnr_pkg.sv]
// Constants, types and field layouts for the board power and NVRAM window registers.
// Assumes a byte-wide ISA-style I/O cycle presented synchronously to the system clock.
//
// Contract
// - The power control register is write-only, 8 bits wide and resets to zero so all subsystems run.
// - Power control bit 6 set powers the serial line drivers down, clear powers them up.
// - Power control bit 5 set disables the speaker amplifier, clear lets audio reach the speaker.
// - Power control bit 4 set powers the audio codec down, clear makes it active.
// - Power control bit 3 set powers the multi-function I/O controller down, clear makes it active.
// - Power control bit 0 clear enables on-board SCSI terminators, set disables them.
// - A write-only low address latch at I/O 0x74 holds NVRAM address bits 7 to 0 and resets to zero.
// - A write-only high address latch at I/O 0x75 holds NVRAM address bits 15 to 8 and resets to zero.
// - A read/write data port at I/O 0x77 moves one byte to or from the latched NVRAM location.
// - With a 13-bit NVRAM part, address bits 13 to 15 have no effect on the access.
// - All these registers are byte registers in the host I/O address space.
package bpnr_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [15:0] BPNR_OFS_ADDR_LOW  = 16'h0074;
    localparam logic [15:0] BPNR_OFS_ADDR_HIGH = 16'h0075;
    localparam logic [15:0] BPNR_OFS_DATA_WIN  = 16'h0077;
    localparam logic [15:0] BPNR_OFS_PWR_CTRL  = 16'h0807;

    // ------------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0]  BPNR_RST_PWR_CTRL  = 8'h00;
    localparam logic [7:0]  BPNR_RST_ADDR      = 8'h00;
    localparam logic [7:0]  BPNR_RST_RDATA     = 8'h00;
    localparam int          BPNR_BIT_SERIAL    = 6;
    localparam int          BPNR_BIT_AMP       = 5;
    localparam int          BPNR_BIT_CODEC     = 4;
    localparam int          BPNR_BIT_MULTI_IO  = 3;
    localparam int          BPNR_BIT_TERM_N    = 0;
    localparam int          BPNR_NV_ADDR_BITS  = 13;
    localparam logic [15:0] BPNR_NV_ADDR_MASK  = 16'h1fff;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        serial_driver_power_off;
        logic        speaker_amp_off;
        logic        codec_power_off;
        logic        multi_io_power_off;
        logic        scsi_term_disable;
    } bpnr_pwr_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } bpnr_nv_req_t;

    typedef enum logic [1:0] {
        BPNR_SEL_NONE = 2'b00,
        BPNR_SEL_LOW  = 2'b01,
        BPNR_SEL_HIGH = 2'b10,
        BPNR_SEL_DATA = 2'b11
    } bpnr_sel_t;

endpackage : bpnr_pkg

// [logic/bpnr_regs.sv]
// Board power control register and indirect NVRAM/RTC access window.
// Assumes one-cycle I/O read and write strobes synchronous to I_CLK_SYS, and an
// NVRAM part that returns read data one cycle after its read strobe.
`timescale 1ns/1ps
`default_nettype none

module bpnr_regs (
    input  wire logic               I_CLK_SYS,
    input  wire logic               I_RESET_N,
    input  wire logic [15:0]        I_IO_ADDR,
    input  wire logic               I_IO_WR,
    input  wire logic               I_IO_RD,
    input  wire logic [7:0]         I_IO_WDATA,
    output logic [7:0]              O_IO_RDATA,
    output logic                    O_IO_RVALID,
    output bpnr_pkg::bpnr_pwr_t     O_PWR,
    output bpnr_pkg::bpnr_nv_req_t  O_NV_REQ,
    input  wire logic [7:0]         I_NV_RDATA
);
    import bpnr_pkg::*;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Full 16-bit compare, so that aliases of the window bytes never reach the part.
    function automatic bpnr_sel_t decode_sel(input logic [15:0] a);
        bpnr_sel_t s;
        s = BPNR_SEL_NONE;
        if (a == BPNR_OFS_ADDR_LOW) begin
            s = BPNR_SEL_LOW;
        end else if (a == BPNR_OFS_ADDR_HIGH) begin
            s = BPNR_SEL_HIGH;
        end else if (a == BPNR_OFS_DATA_WIN) begin
            s = BPNR_SEL_DATA;
        end
        return s;
    endfunction : decode_sel

    // Decode results and the state of the three writable byte registers.
    bpnr_sel_t   sel;
    logic        pwr_hit;
    logic [7:0]  pwr_ctrl_ff;
    logic [7:0]  addr_low_latch_ff;
    logic [7:0]  addr_high_latch_ff;
    logic        rd_pend_ff;
    logic [15:0] nv_addr;

    // Byte registers in I/O space; every decode is a full 16-bit match.
    assign sel     = decode_sel(I_IO_ADDR);
    assign pwr_hit = (I_IO_ADDR == BPNR_OFS_PWR_CTRL);
    // Upper address bits are masked off so a 13-bit part never sees them.
    assign nv_addr = {addr_high_latch_ff, addr_low_latch_ff} & BPNR_NV_ADDR_MASK;

    // ------------------------------------------------------------------
    // Power-down control register
    // ------------------------------------------------------------------
    // Write-only; resets to zero so everything is powered after reset.
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESET_N) begin
            pwr_ctrl_ff <= BPNR_RST_PWR_CTRL;
        end else if (I_IO_WR && pwr_hit) begin
            pwr_ctrl_ff <= I_IO_WDATA;
        end
    end

    // Outputs are registered once more so each control pin leaves a flip-flop.
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESET_N) begin
            O_PWR <= '0;
        end else begin
            O_PWR.serial_driver_power_off <= pwr_ctrl_ff[BPNR_BIT_SERIAL];
            O_PWR.speaker_amp_off         <= pwr_ctrl_ff[BPNR_BIT_AMP];
            O_PWR.codec_power_off         <= pwr_ctrl_ff[BPNR_BIT_CODEC];
            O_PWR.multi_io_power_off      <= pwr_ctrl_ff[BPNR_BIT_MULTI_IO];
            O_PWR.scsi_term_disable       <= pwr_ctrl_ff[BPNR_BIT_TERM_N];
        end
    end

    // ------------------------------------------------------------------
    // Address latches
    // ------------------------------------------------------------------
    // Latches change only on their own writes; data port traffic leaves them alone.
    // Writing high before low is accepted; the access uses whatever both latches hold.
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESET_N) begin
            addr_low_latch_ff  <= BPNR_RST_ADDR;
            addr_high_latch_ff <= BPNR_RST_ADDR;
        end else if (I_IO_WR) begin
            if (sel == BPNR_SEL_LOW) begin
                addr_low_latch_ff <= I_IO_WDATA;
            end
            if (sel == BPNR_SEL_HIGH) begin
                addr_high_latch_ff <= I_IO_WDATA;
            end
        end
    end

    // ------------------------------------------------------------------
    // Data window toward the NVRAM part
    // ------------------------------------------------------------------
    // A data port access issues a one-cycle strobe with the latched address.
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESET_N) begin
            O_NV_REQ <= '0;
        end else begin
            O_NV_REQ.rd    <= I_IO_RD && (sel == BPNR_SEL_DATA);
            O_NV_REQ.wr    <= I_IO_WR && (sel == BPNR_SEL_DATA);
            // Address and data ride along every cycle; only the strobes carry meaning.
            O_NV_REQ.addr  <= nv_addr;
            O_NV_REQ.wdata <= I_IO_WDATA;
        end
    end

    // Read return: the NVRAM answers a cycle after its strobe.
    // A plain read answers a cycle later, so an overlapping plain read loses its slot to the window answer.
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESET_N) begin
            rd_pend_ff  <= 1'b0;
            O_IO_RVALID <= 1'b0;
            O_IO_RDATA  <= BPNR_RST_RDATA;
        end else begin
            rd_pend_ff  <= O_NV_REQ.rd;
            O_IO_RVALID <= 1'b0;
            if (rd_pend_ff) begin
                O_IO_RDATA  <= I_NV_RDATA;
                O_IO_RVALID <= 1'b1;
            end else if (I_IO_RD && sel != BPNR_SEL_DATA) begin
                // Write-only and unmapped locations read as zero.
                O_IO_RDATA  <= BPNR_RST_RDATA;
                O_IO_RVALID <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // Every check names its own clock and reset, so it can move with the logic it guards.
    sequence s_data_read;
        I_IO_RD && sel == BPNR_SEL_DATA;
    endsequence

    sequence s_data_write;
        I_IO_WR && sel == BPNR_SEL_DATA;
    endsequence

    // A power write passes the holding flop and then the output flop.
    sequence s_pwr_write_settled;
        I_IO_WR && pwr_hit ##2 1'b1;
    endsequence

    // A read of a write-only or unmapped byte with no window answer in its way.
    sequence s_plain_read;
        I_IO_RD && sel != BPNR_SEL_DATA && !rd_pend_ff;
    endsequence

    // Power register: reset value, write path to every control pin, and hold.
    a_pwr_reset_zero: assert property (@(posedge I_CLK_SYS)
        $rose(I_RESET_N) |-> pwr_ctrl_ff == BPNR_RST_PWR_CTRL && O_PWR == '0)
        else $error("power register not zero after reset");

    a_serial_follows: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        s_pwr_write_settled |-> O_PWR.serial_driver_power_off == $past(I_IO_WDATA[BPNR_BIT_SERIAL], 2))
        else $error("serial power bit wrong");

    a_amp_follows: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        s_pwr_write_settled |-> O_PWR.speaker_amp_off == $past(I_IO_WDATA[BPNR_BIT_AMP], 2))
        else $error("amplifier bit wrong");

    a_codec_follows: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        s_pwr_write_settled |-> O_PWR.codec_power_off == $past(I_IO_WDATA[BPNR_BIT_CODEC], 2))
        else $error("codec bit wrong");

    a_multi_io_follows: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        s_pwr_write_settled |-> O_PWR.multi_io_power_off == $past(I_IO_WDATA[BPNR_BIT_MULTI_IO], 2))
        else $error("multi io bit wrong");

    a_term_follows: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        s_pwr_write_settled |-> O_PWR.scsi_term_disable == $past(I_IO_WDATA[BPNR_BIT_TERM_N], 2))
        else $error("terminator bit wrong");

    a_pwr_holds: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        !(I_IO_WR && pwr_hit) |=> $stable(pwr_ctrl_ff))
        else $error("power register moved without its write");

    a_wo_read_zero: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        s_plain_read |=> O_IO_RVALID && O_IO_RDATA == BPNR_RST_RDATA)
        else $error("write-only byte did not read as zero");

    // Address latches: reset value, loads, and no movement without a write.
    a_latch_reset_zero: assert property (@(posedge I_CLK_SYS)
        $rose(I_RESET_N) |-> addr_low_latch_ff == BPNR_RST_ADDR && addr_high_latch_ff == BPNR_RST_ADDR)
        else $error("address latches not zero after reset");

    a_low_latch_load: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        I_IO_WR && sel == BPNR_SEL_LOW |=> addr_low_latch_ff == $past(I_IO_WDATA))
        else $error("low latch not loaded");

    a_high_latch_load: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        I_IO_WR && sel == BPNR_SEL_HIGH |=> addr_high_latch_ff == $past(I_IO_WDATA))
        else $error("high latch not loaded");

    a_latch_no_incr: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        !(I_IO_WR && (sel == BPNR_SEL_LOW || sel == BPNR_SEL_HIGH)) |=> $stable(nv_addr))
        else $error("address latch moved without a write");

    // Data window: strobes toward the part and the answer back to the host.
    a_read_return: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        s_data_read |-> ##1 O_NV_REQ.rd ##1 1'b1 ##1 (O_IO_RVALID && O_IO_RDATA == $past(I_NV_RDATA)))
        else $error("data window read not returned");

    a_write_strobe: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        s_data_write |=> O_NV_REQ.wr && O_NV_REQ.wdata == $past(I_IO_WDATA) && O_NV_REQ.addr == $past(nv_addr))
        else $error("data window write not passed to the part");

    a_no_stray_read: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        !(I_IO_RD && sel == BPNR_SEL_DATA) |=> !O_NV_REQ.rd)
        else $error("read strobe without a window read");

    a_no_stray_write: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        !(I_IO_WR && sel == BPNR_SEL_DATA) |=> !O_NV_REQ.wr)
        else $error("write strobe without a window write");

    a_rdata_holds: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        !rd_pend_ff && !I_IO_RD |=> !O_IO_RVALID && $stable(O_IO_RDATA))
        else $error("read answer appeared without a read");

    a_addr_masked: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        (O_NV_REQ.rd || O_NV_REQ.wr) |-> (O_NV_REQ.addr >> BPNR_NV_ADDR_BITS) == 16'h0000)
        else $error("upper address bits reached the part");

endmodule : bpnr_regs

`default_nettype wire

// [bench/bpnr_nv_model.sv]
// Behavioural model of the battery-backed NVRAM/RTC part behind the data window.
// Assumes the request struct of bpnr_pkg, sampled on the system clock.
`timescale 1ns/1ps
`default_nettype none

module bpnr_nv_model
    import bpnr_pkg::*;
(
    input  wire logic                   i_clk,
    input  wire bpnr_pkg::bpnr_nv_req_t i_req,
    output logic [7:0]                  o_rdata
);
    logic [7:0] mem_ff [0:8191];

    // Only 13 address bits reach the array, so upper bits alias.
    always_ff @(posedge i_clk) begin
        if (i_req.wr) begin
            mem_ff[i_req.addr[12:0]] <= i_req.wdata;
        end
    end

    // Data stands one cycle, then toggles so a late sample is caught.
    always_ff @(posedge i_clk) begin
        if (i_req.rd) begin
            o_rdata <= mem_ff[i_req.addr[12:0]];
        end else begin
            o_rdata <= ~o_rdata;
        end
    end
endmodule : bpnr_nv_model

`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the board power and NVRAM window registers.
// Assumes bpnr_regs and the NVRAM model; inputs change on falling edges.
`timescale 1ns/1ps
`default_nettype none

module tb;
    import bpnr_pkg::*;
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic [15:0]  io_addr = 16'h0000;
    logic         io_wr = 1'b0;
    logic         io_rd = 1'b0;
    logic [7:0]   io_wdata = 8'h00;
    logic [7:0]   io_rdata;
    logic [7:0]   nv_rdata;
    logic         io_rvalid;
    bpnr_pwr_t    pwr;
    bpnr_nv_req_t nv_req;
    logic [7:0]   exp_q [$];
    int           err_total = 0;
    int           tests_run = 0;
    int           cycles = 0;
    logic [15:0]  a;
    logic [7:0]   d;

    always #4 clk = ~clk;

    bpnr_regs dut (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_IO_ADDR(io_addr), .I_IO_WR(io_wr),
        .I_IO_RD(io_rd), .I_IO_WDATA(io_wdata), .O_IO_RDATA(io_rdata), .O_IO_RVALID(io_rvalid),
        .O_PWR(pwr), .O_NV_REQ(nv_req), .I_NV_RDATA(nv_rdata));
    bpnr_nv_model nv (.i_clk(clk), .i_req(nv_req), .o_rdata(nv_rdata));

    // ------------------------------------------------------------------
    // Bus tasks and comparison
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic bus_wr(input logic [15:0] adr, input logic [7:0] dat);
        @(negedge clk);
        io_addr = adr;
        io_wdata = dat;
        io_wr = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
    endtask : bus_wr

    // Reads are spaced three cycles so answers never overlap.
    task automatic bus_rd(input logic [15:0] adr, input logic [7:0] exp);
        exp_q.push_back(exp);
        @(negedge clk);
        io_addr = adr;
        io_rd = 1'b1;
        @(negedge clk);
        io_rd = 1'b0;
        repeat (3) @(negedge clk);
    endtask : bus_rd

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    // Watcher: every read answer takes the oldest expectation.
    always @(negedge clk) begin
        cycles++;
        if (cycles > 2000) begin
            err_total++;
            give_verdict();
        end else if (io_rvalid === 1'b1) begin
            if (exp_q.size() == 0) chk(32'h1, 32'h0);
            else chk(io_rdata, exp_q.pop_front());
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'h8f03));
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        chk(pwr, 5'h00);
        chk(nv_req.addr, 16'h0000);
        bus_rd(BPNR_OFS_PWR_CTRL, 8'h00);
        // Walking ones, then random bytes, through the power control.
        for (int i = 0; i < 12; i++) begin
            d = (i < 8) ? (8'h01 << i) : 8'($urandom);
            bus_wr(BPNR_OFS_PWR_CTRL, d);
            @(negedge clk);
            chk(pwr, {d[6], d[5], d[4], d[3], d[0]});
        end
        bus_wr(16'h0806, ~d);
        @(negedge clk);
        chk(pwr, {d[6], d[5], d[4], d[3], d[0]});
        bus_rd(BPNR_OFS_PWR_CTRL, 8'h00);
        // Random locations, top address bits included, then aliased reads.
        for (int i = 0; i < 6; i++) begin
            a = 16'($urandom);
            d = 8'($urandom);
            bus_wr(BPNR_OFS_ADDR_LOW, a[7:0]);
            bus_wr(BPNR_OFS_ADDR_HIGH, a[15:8]);
            bus_wr(BPNR_OFS_DATA_WIN, d);
            chk({nv_req.wr, nv_req.addr, nv_req.wdata}, {1'b1, a & BPNR_NV_ADDR_MASK, d});
            bus_rd(BPNR_OFS_DATA_WIN, d);
            bus_rd(BPNR_OFS_DATA_WIN, d);
            bus_wr(BPNR_OFS_ADDR_HIGH, a[15:8] ^ 8'he0);
            bus_rd(BPNR_OFS_DATA_WIN, d);
        end
        bus_rd(BPNR_OFS_ADDR_LOW, 8'h00);
        bus_rd(16'h0076, 8'h00);
        repeat (5) @(negedge clk);
        chk(exp_q.size(), 0);
        give_verdict();
    end
endmodule : tb

`default_nettype wire
